/* File: common/ccl_map.svh */
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH

// register byte addresses on the wishbone bus
`define CCL_CC_ADDR        32'hffffffec
`define CCL_LC_ADDR        32'h040000b0

// cache_control field positions
`define CCL_CC_ENABLE      0
`define CCL_CC_GEN_POLICY  1
`define CCL_CC_KER_POLICY  2
`define CCL_CC_FLUSH       3
`define CCL_CC_RESET       32'h00000000

// cache_lock_control field positions
`define CCL_LC_WAY2_LOCK   0
`define CCL_LC_WAY2_LOAD   1
`define CCL_LC_WAY3_LOCK   8
`define CCL_LC_WAY3_LOAD   9
`define CCL_LC_RESET       32'h00000000

// cache_lock_mode position in the processor status register
`define CCL_SR_LOCK_BIT    12

// geometry
`define CCL_SETS           256
`define CCL_INDEX_W        8
`define CCL_WAYS           4
`define CCL_LRU_W          6

`endif

/* File: common/ccl_pkg.sv */
`include "ccl_map.svh"

package ccl_pkg;

    typedef enum logic [3:0] {
        ST_CLEAR = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_LOOK  = 4'b0100,
        ST_MRST  = 4'b1000
    } ccl_state_e;

    typedef enum logic [2:0] {
        KIND_READ = 3'b001,
        KIND_WRITE = 3'b010,
        KIND_PREFETCH_INSTR = 3'b100
    } ccl_kind_e;

    typedef logic [`CCL_INDEX_W-1:0] ccl_index_t;
    typedef logic [`CCL_LRU_W-1:0]   ccl_lru_t;

    // per-set state held in the array
    typedef struct packed {
        logic [`CCL_WAYS-1:0] valid;
        logic [`CCL_WAYS-1:0] dirty;
        ccl_lru_t             lru;
    } ccl_entry_s;

    // core access request, tag search result included
    typedef struct packed {
        ccl_kind_e  kind;
        ccl_index_t index;
        logic       hit;
        logic [1:0] hit_way;
        logic       kernel_area;
    } ccl_req_s;

    typedef struct packed {
        logic       bypass;
        logic       hit;
        logic       allocate;
        logic [1:0] way;
        logic       writeback;
        logic       wb_mode;
    } ccl_resp_s;

    typedef struct packed {
        logic way2_lock;
        logic way2_load;
        logic way3_lock;
        logic way3_load;
    } ccl_lock_s;

endpackage : ccl_pkg

/* File: logic/ccl_state_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module ccl_state_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8,
    parameter int WIDTH = 14
) (
    input  wire logic             clk_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule : ccl_state_mem

`default_nettype wire

/* File: logic/ccl_top.sv */
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

`include "ccl_map.svh"

module ccl_top
    import ccl_pkg::*;
#(
    parameter int SETS    = `CCL_SETS,
    parameter int INDEX_W = `CCL_INDEX_W
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        manual_rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // core side
    input  wire logic [31:0] processor_status_reg_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire ccl_req_s    req_i,
    output logic             resp_valid_o,
    output ccl_resp_s        resp_o,
    output logic             cache_enable_o,
    output logic             busy_o
);

    localparam int EW = $bits(ccl_entry_s);

    typedef struct packed {
        ccl_state_e       state;
        logic [INDEX_W-1:0] cnt;
        logic             ack;
        logic [31:0]      rdat;
        logic             enable;
        logic             gen_policy;
        logic             ker_policy;
        ccl_lock_s        lock;
        logic             flush_pend;
        ccl_req_s         req;
        ccl_resp_s        resp;
        logic             resp_valid;
    } ccl_regs_s;

    ccl_regs_s            q;
    ccl_regs_s            d;
    ccl_entry_s           ent_rd;
    ccl_entry_s           ent_wr;
    logic [EW-1:0]        mem_rdata;
    logic                 mem_we;
    logic [INDEX_W-1:0]   mem_waddr;
    logic [1:0]           victim;
    logic                 lock_mode;

    ////////////////////////////////////////////////////////////////////////

    // newest-use update of the pairwise lru code
    function automatic ccl_lru_t lru_touch(input ccl_lru_t l,
                                           input logic [1:0] w);
        ccl_lru_t r;
        r = l;
        unique case (w)
            2'd0: begin
                r[5] = 1'b0;
                r[4] = 1'b0;
                r[3] = 1'b0;
            end
            2'd1: begin
                r[5] = 1'b1;
                r[2] = 1'b0;
                r[1] = 1'b0;
            end
            2'd2: begin
                r[4] = 1'b1;
                r[2] = 1'b1;
                r[0] = 1'b0;
            end
            2'd3: begin
                r[3] = 1'b1;
                r[1] = 1'b1;
                r[0] = 1'b1;
            end
        endcase
        return r;
    endfunction : lru_touch

    function automatic logic [3:0] way_bit(input logic [1:0] w);
        return 4'h1 << w;
    endfunction : way_bit

    ////////////////////////////////////////////////////////////////////////

    assign lock_mode = processor_status_reg_i[`CCL_SR_LOCK_BIT];
    assign ent_rd    = ccl_entry_s'(mem_rdata);

    ccl_state_mem #(
        .DEPTH (SETS),
        .AW    (INDEX_W),
        .WIDTH (EW)
    ) u_mem (
        .clk_i   (clk_i),
        .raddr_i (req_i.index[INDEX_W-1:0]),
        .rdata_o (mem_rdata),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (ent_wr)
    );

    ccl_victim u_victim (
        .lock_mode_i (lock_mode),
        .prefetch_i  (q.req.kind == KIND_PREFETCH_INSTR),
        .lock_i      (q.lock),
        .lru_i       (ent_rd.lru),
        .way_o       (victim)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic wb_mode;
        logic alloc;
        logic is_write;
        wb_mode  = 1'b0;
        alloc    = 1'b0;
        is_write = 1'b0;
        d            = q;
        d.resp_valid = 1'b0;
        mem_we       = 1'b0;
        mem_waddr    = q.req.index[INDEX_W-1:0];
        ent_wr       = ent_rd;

        // access state machine
        unique case (q.state)
            ST_CLEAR: begin
                mem_we    = 1'b1;
                mem_waddr = q.cnt;
                ent_wr    = '0;
                d.cnt     = q.cnt + 1'b1;
                if (q.cnt == INDEX_W'(SETS - 1)) begin
                    d.state = ST_IDLE;
                end
            end
            ST_MRST: begin
                d.state = ST_IDLE;
            end
            ST_IDLE: begin
                if (q.flush_pend) begin
                    d.flush_pend = 1'b0;
                    d.cnt        = '0;
                    d.state      = ST_CLEAR;
                end else if (req_valid_i) begin
                    d.req   = req_i;
                    d.state = ST_LOOK;
                end
            end
            ST_LOOK: begin
                is_write = (q.req.kind == KIND_WRITE);
                wb_mode  = q.req.kernel_area ? q.ker_policy
                                             : !q.gen_policy;
                d.state        = ST_IDLE;
                d.resp_valid   = 1'b1;
                d.resp         = '0;
                d.resp.wb_mode = wb_mode;
                if (!q.enable) begin
                    d.resp.bypass = 1'b1;
                end else if (q.req.hit) begin
                    d.resp.hit = 1'b1;
                    d.resp.way = q.req.hit_way;
                    mem_we     = 1'b1;
                    ent_wr.lru = lru_touch(ent_rd.lru, q.req.hit_way);
                    if (is_write && wb_mode) begin
                        ent_wr.dirty = ent_rd.dirty | way_bit(q.req.hit_way);
                    end
                    // prefetch hit: only lru moves, no fill
                end else begin
                    alloc = !(is_write && !wb_mode);
                    if (alloc) begin
                        mem_we           = 1'b1;
                        d.resp.allocate  = 1'b1;
                        d.resp.way       = victim;
                        d.resp.writeback = ent_rd.valid[victim]
                                           & ent_rd.dirty[victim];
                        ent_wr.valid = ent_rd.valid | way_bit(victim);
                        ent_wr.dirty = is_write
                                       ? (ent_rd.dirty | way_bit(victim))
                                       : (ent_rd.dirty & ~way_bit(victim));
                        ent_wr.lru   = lru_touch(ent_rd.lru, victim);
                    end
                end
            end
        endcase

        if (manual_rst_i) begin
            d.state      = ST_MRST;
            d.enable     = 1'b0;
            d.gen_policy = 1'b0;
            d.ker_policy = 1'b0;
            d.lock       = '0;
            d.flush_pend = 1'b0;
        end

        // wishbone register access, after the machine so a flush set wins
        d.ack  = wb_cyc_i && wb_stb_i && !q.ack;
        d.rdat = '0;
        if (d.ack && !wb_we_i) begin
            if (wb_adr_i == `CCL_CC_ADDR) begin
                d.rdat[`CCL_CC_ENABLE]     = q.enable;
                d.rdat[`CCL_CC_GEN_POLICY] = q.gen_policy;
                d.rdat[`CCL_CC_KER_POLICY] = q.ker_policy;
            end
            // lock control reads back zero
        end
        // writes land at the edge where the master sees ack
        if (q.ack && wb_cyc_i && wb_stb_i && wb_we_i
            && !manual_rst_i) begin
            if (wb_adr_i == `CCL_CC_ADDR && wb_sel_i[0]) begin
                d.enable     = wb_dat_i[`CCL_CC_ENABLE];
                d.gen_policy = wb_dat_i[`CCL_CC_GEN_POLICY];
                d.ker_policy = wb_dat_i[`CCL_CC_KER_POLICY];
                if (wb_dat_i[`CCL_CC_FLUSH]) begin
                    d.flush_pend = 1'b1;
                end
            end
            if (wb_adr_i == `CCL_LC_ADDR) begin
                if (wb_sel_i[0]) begin
                    d.lock.way2_lock = wb_dat_i[`CCL_LC_WAY2_LOCK];
                    d.lock.way2_load = wb_dat_i[`CCL_LC_WAY2_LOAD];
                end
                if (wb_sel_i[1]) begin
                    d.lock.way3_lock = wb_dat_i[`CCL_LC_WAY3_LOCK];
                    d.lock.way3_load = wb_dat_i[`CCL_LC_WAY3_LOAD];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q            <= '0;
            q.state      <= ST_CLEAR;
            q.enable     <= 1'(`CCL_CC_RESET >> `CCL_CC_ENABLE);
            q.lock       <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign wb_ack_o       = q.ack;
    assign wb_dat_o       = q.rdat;
    assign req_ready_o    = (q.state == ST_IDLE) && !q.flush_pend;
    assign resp_valid_o   = q.resp_valid;
    assign resp_o         = q.resp;
    assign cache_enable_o = q.enable;
    assign busy_o         = (q.state == ST_CLEAR) || q.flush_pend;

endmodule : ccl_top

`default_nettype wire

/* File: logic/ccl_victim.sv */
`timescale 1ns/10ps
`default_nettype none

module ccl_victim
    import ccl_pkg::*;
(
    input  wire logic      lock_mode_i,
    input  wire logic      prefetch_i,
    input  wire ccl_lock_s lock_i,
    input  wire ccl_lru_t  lru_i,
    output logic [1:0]     way_o
);

    // pair bits: 5=0/1 4=0/2 3=0/3 2=1/2 1=1/3 0=2/3, one = lower older
    function automatic logic [1:0] pick_all(input ccl_lru_t l);
        if (l[5] && l[4] && l[3])            pick_all = 2'd0;
        else if (!l[5] && l[2] && l[1])      pick_all = 2'd1;
        else if (!l[4] && !l[2] && l[0])     pick_all = 2'd2;
        else                                 pick_all = 2'd3;
    endfunction : pick_all

    function automatic logic [1:0] pick_no2(input ccl_lru_t l);
        if (l[5] && l[3])                    pick_no2 = 2'd0;
        else if (!l[5] && l[1])              pick_no2 = 2'd1;
        else                                 pick_no2 = 2'd3;
    endfunction : pick_no2

    function automatic logic [1:0] pick_no3(input ccl_lru_t l);
        if (l[5] && l[4])                    pick_no3 = 2'd0;
        else if (!l[5] && l[2])              pick_no3 = 2'd1;
        else                                 pick_no3 = 2'd2;
    endfunction : pick_no3

    always_comb begin
        way_o = pick_all(lru_i);
        if (lock_mode_i) begin
            if (prefetch_i && lock_i.way2_lock && lock_i.way2_load) begin
                way_o = 2'd2;
            end else if (prefetch_i && lock_i.way3_lock
                         && lock_i.way3_load) begin
                way_o = 2'd3;
            end else if (lock_i.way2_lock && lock_i.way3_lock) begin
                way_o = lru_i[5] ? 2'd0 : 2'd1;
            end else if (lock_i.way2_lock) begin
                way_o = pick_no2(lru_i);
            end else if (lock_i.way3_lock) begin
                way_o = pick_no3(lru_i);
            end
        end
    end

endmodule : ccl_victim

`default_nettype wire

/* File: sim/ccl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccl_map.svh"
module ccl_chk
    import ccl_pkg::*;
#(
    parameter int SETS = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        req_valid_i,
    input wire logic        req_ready_o,
    input wire ccl_req_s    req_i,
    input wire logic        resp_valid_o,
    input wire ccl_resp_s   resp_o,
    input wire logic        cache_enable_o,
    input wire logic        busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    assign take = req_valid_i && req_ready_o;
    ////////////////////////////////////////////////////////////
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    a_ack_prompt: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    a_unused_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == `CCL_CC_ADDR |-> wb_dat_o[31:3] == 29'h0)
        else $error("cache control upper bits not zero");
    a_resp_two: assert property (take |-> ##2 resp_valid_o)
        else $error("response not two cycles after take");
    a_resp_pulse: assert property (resp_valid_o |=> !resp_valid_o)
        else $error("response valid held");
    a_busy_stall: assert property (busy_o |-> !req_ready_o)
        else $error("ready while busy");
    a_bypass_off: assert property (resp_valid_o |->
        resp_o.bypass == !$past(cache_enable_o, 1))
        else $error("bypass does not follow enable");
    a_hit_keep: assert property (take && req_i.hit && cache_enable_o |->
        ##2 resp_o.hit && !resp_o.allocate &&
        resp_o.way == $past(req_i.hit_way, 2))
        else $error("hit not kept in its way");
    a_flush_start: assert property (wb_ack_o && wb_we_i &&
        wb_adr_i == `CCL_CC_ADDR && wb_sel_i[0] &&
        wb_dat_i[`CCL_CC_FLUSH] |=> busy_o)
        else $error("flush did not start");
    a_clear_walk: assert property ($fell(rst_i) |-> ##2 busy_o [*8])
        else $error("no clear walk after reset");
    c_prefetch_instr_miss: cover property (take && req_i.kind == KIND_PREFETCH_INSTR && !req_i.hit);
    c_writeback: cover property (resp_valid_o && resp_o.writeback);
    c_bypass: cover property (resp_valid_o && resp_o.bypass);
endmodule : ccl_chk
bind ccl_top ccl_chk #(.SETS(SETS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .resp_valid_o(resp_valid_o),
    .resp_o(resp_o), .cache_enable_o(cache_enable_o), .busy_o(busy_o));
`default_nettype wire

/* File: sim/ccl_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ccl_core_model
    import ccl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic req_ready_i,
    output logic      req_valid_o,
    output ccl_req_s  req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // one request outstanding, held until taken
    task automatic issue(input ccl_req_s r, input int gap);
        repeat (gap) @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o <= r;
        do @(posedge clk_i); while (req_ready_i !== 1'b1);
        req_valid_o <= 1'b0;
        req_o <= ~r;
    endtask : issue
endmodule : ccl_core_model
`default_nettype wire

/* File: sim/tb_cache_control_and_way_lock.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccl_map.svh"
module tb_cache_control_and_way_lock
    import ccl_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        mrst = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] sr = 32'h0;
    logic [31:0] dat_o, rd;
    logic        ack, rdy, rv, en, busy, rq_v;
    ccl_req_s    rq;
    ccl_resp_s   rs;
    logic [3:0]  vld[16], drt[16], lk;
    logic [5:0]  lru[16];
    logic [2:0]  cc;
    int          fail_count = 0, checks_done = 0;
    int          seed = 32'h4d6b5720;

    always #25 clk_i = ~clk_i;

    ccl_top #(.SETS(16), .INDEX_W(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .manual_rst_i(mrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .processor_status_reg_i(sr), .req_valid_i(rq_v),
        .req_ready_o(rdy), .req_i(rq), .resp_valid_o(rv), .resp_o(rs),
        .cache_enable_o(en), .busy_o(busy));
    ccl_core_model core (.clk_i(clk_i), .req_ready_i(rdy),
        .req_valid_o(rq_v), .req_o(rq));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wbx(input logic w, input logic [31:0] a, d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wbx

    task automatic wcc(input logic [31:0] d);
        wbx(1'b1, `CCL_CC_ADDR, d);
        cc = d[2:0];
        if (d[3]) begin
            foreach (vld[i]) {vld[i], drt[i], lru[i]} = '0;
            chk(busy, 1);
            while (busy !== 1'b0) @(posedge clk_i);
        end
    endtask : wcc

    function automatic int pidx(int a, int b);
        return a == 0 ? 6 - b : (a == 1 ? 4 - b : 0);
    endfunction : pidx

    function automatic logic [1:0] oldest(logic [5:0] l, logic [3:0] m);
        logic ok;
        oldest = 2'h0;
        for (int w = 0; w < 4; w++) begin
            ok = m[w];
            for (int o = 0; o < 4; o++)
                if (o != w && m[o] && (w < o ? !l[pidx(w, o)] : l[pidx(o, w)]))
                    ok = 1'b0;
            if (ok) oldest = 2'(w);
        end
    endfunction : oldest

    task automatic acc(input ccl_kind_e k);
        ccl_req_s  r;
        ccl_resp_s e;
        logic [1:0] v;
        logic lm, wbm, wr;
        int s;
        s = $unsigned($random(seed)) % 4;
        r.kind = k;
        r.index = ccl_index_t'(s);
        r.hit_way = 2'($random(seed));
        r.hit = vld[s][r.hit_way] & 1'($random(seed));
        r.kernel_area = 1'($random(seed));
        wr = (k == KIND_WRITE);
        lm = sr[12];
        wbm = r.kernel_area ? cc[2] : !cc[1];
        if (r.hit) v = r.hit_way;
        else if (lm && k == KIND_PREFETCH_INSTR && lk[1:0] == 2'b11) v = 2'd2;
        else if (lm && k == KIND_PREFETCH_INSTR && lk[3:2] == 2'b11) v = 2'd3;
        else v = oldest(lru[s], {~(lm & lk[2]), ~(lm & lk[0]), 2'b11});
        e = '0;
        e.allocate = !r.hit && !(wr && !wbm);
        e.writeback = e.allocate && vld[s][v] && drt[s][v];
        core.issue(r, $unsigned($random(seed)) % 3);
        while (rv !== 1'b1) @(posedge clk_i);
        if (!cc[0]) chk(rs.bypass, 1);
        else begin
            chk({rs.bypass, rs.hit, rs.allocate, rs.writeback, rs.wb_mode},
                {1'b0, r.hit, e.allocate, e.writeback, wbm});
            if (r.hit || e.allocate) chk(rs.way, v);
            if (r.hit || e.allocate)
                for (int o = 0; o < 4; o++)
                    if (o != v) lru[s][o < v ? pidx(o, v) : pidx(v, o)] = o < v;
            if (e.allocate) {vld[s][v], drt[s][v]} = {1'b1, wr};
            if (r.hit && wr && wbm) drt[s][v] = 1'b1;
        end
    endtask : acc

    task automatic traffic(input int n);
        repeat (n) acc(ccl_kind_e'(3'h1 << ($unsigned($random(seed)) % 3)));
    endtask : traffic

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end

    initial begin
        foreach (vld[i]) {vld[i], drt[i], lru[i]} = '0;
        {cc, lk} = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        while (rdy !== 1'b1) @(posedge clk_i);
        wbx(1'b0, `CCL_CC_ADDR, 0);
        chk(rd, 0);
        wbx(1'b0, `CCL_LC_ADDR, 0);
        chk(rd, 0);
        wbx(1'b0, 32'h00000100, 0);
        chk(rd, 0);
        wcc(32'hfffffff7);
        wbx(1'b0, `CCL_CC_ADDR, 0);
        chk(rd, 7);
        $display("test registers done");
        // lock settings 0,1,3,4,c,5,7,8, never both load bits
        for (int p = 0; p < 16; p++) begin
            lk = 4'(32'h875c4310 >> (p / 2 * 4));
            sr <= {19'($random(seed)), p[0], 12'($random(seed))};
            wbx(1'b1, `CCL_LC_ADDR, {22'h0, lk[3:2], 6'h0, lk[1:0]});
            wcc({29'h0, 3'($random(seed)) | 3'h1});
            traffic(20);
        end
        $display("test lock traffic done");
        wcc(0);
        traffic(6);
        wcc(32'h9);
        traffic(20);
        $display("test flush done");
        mrst <= 1'b1;
        @(posedge clk_i);
        mrst <= 1'b0;
        @(posedge clk_i);
        {cc, lk} = '0;
        wbx(1'b0, `CCL_CC_ADDR, 0);
        chk(rd, 0);
        wcc(1);
        traffic(20);
        $display("test manual reset done");
        report_and_stop();
    end
endmodule : tb_cache_control_and_way_lock
`default_nettype wire
